// ==== core/sdas_defs.svh ====
/*
 * register indexes, field positions, reset values and counts of the
 * delta-sigma converter sequencer.
 * assumes: included by bare name from the package and the sequencer.
 */
`ifndef SDAS_DEFS_SVH
`define SDAS_DEFS_SVH

// register indexes; byte address on the bus is four times the index
`define SDAS_IDX_AUX_STAT 8'ha7
`define SDAS_IDX_AUX_MASK 8'ha8
`define SDAS_IDX_RESULT 8'hd9
`define SDAS_IDX_CTRL_ONE 8'hdd
`define SDAS_IDX_DEC_LOW 8'hde
`define SDAS_IDX_DEC_HIGH 8'hdf
`define SDAS_IDX_ACLK 8'hf6

// conversion_control_one fields
`define SDAS_CAL_LSB 0
`define SDAS_FILT_LSB 4

// calibration_mode_field codes
`define SDAS_CAL_NONE 3'h0
`define SDAS_CAL_SELF_BOTH 3'h1
`define SDAS_CAL_SELF_OFS 3'h2
`define SDAS_CAL_SELF_GAIN 3'h3
`define SDAS_CAL_SYS_OFS 3'h4
`define SDAS_CAL_SYS_GAIN 3'h5

// filter select field codes
`define SDAS_FSEL_AUTO 2'h0
`define SDAS_FSEL_FAST 2'h1
`define SDAS_FSEL_SINC2 2'h2
`define SDAS_FSEL_SINC3 2'h3

// aux_interrupt_status bit positions
`define SDAS_STAT_CONV 5
`define SDAS_STAT_CAL 4

// reset values
`define SDAS_ACLK_RST 8'h00
`define SDAS_DEC_LOW_RST 8'h00
`define SDAS_DEC_HIGH_RST 8'h01
`define SDAS_CTRL_RST 8'h00
`define SDAS_MASK_RST 8'h00

// counts
`define SDAS_MOD_DIV_LAST 6'h3f
`define SDAS_CAL_PERIODS 5'h07
`define SDAS_CAL_PERIODS_BOTH 5'h0e
`define SDAS_AUTO_FAST_CONV 2'h2

`endif

// ==== core/sdas_pkg.sv ====
/*
 * types shared by the converter sequencer.
 * assumes: sdas_defs.svh is on the include path.
 */
`include "sdas_defs.svh"

package sdas_pkg;
    // calibration sequencer state
    typedef enum logic {SDAS_CAL_IDLE, SDAS_CAL_RUN} sdas_cal_state_e;
    // filter applied to the conversion in progress
    typedef enum logic [1:0] {SDAS_FILT_FAST, SDAS_FILT_SINC2, SDAS_FILT_SINC3} sdas_filt_e;
endpackage

// ==== core/sdas_sequencer.sv ====
/*
 * control logic of a delta-sigma converter: modulator clock divider,
 * decimation counter, calibration sequencer, output filter selection,
 * interrupt status and an Avalon-MM register slave.
 * assumes: one clock, synchronous inputs; the analog modulator and the
 * filter datapath sit outside and hand in the result word.
 */
`timescale 1ns/10ps
`include "sdas_defs.svh"

module sdas_sequencer
    import sdas_pkg::*;
#(
    parameter int DEC_W = 11,
    parameter int RES_W = 24
) (
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic I_CE,
    input wire logic [9:0] I_ADDRESS,
    input wire logic I_READ,
    input wire logic I_WRITE,
    input wire logic [31:0] I_WRITEDATA,
    input wire logic [3:0] I_BYTEENABLE,
    output logic O_WAITREQUEST,
    output logic [31:0] O_READDATA,
    input wire logic I_INPUT_CHANGE,
    input wire logic [RES_W-1:0] I_RESULT,
    output logic O_MOD_TICK,
    output logic O_WORD_TICK,
    output logic [2:0] O_CAL_MODE,
    output logic O_CAL_BUSY,
    output logic [1:0] O_FILTER_SEL,
    output logic O_DISCARD,
    output logic O_IRQ
);
    // software registers
    logic [7:0] aclk_div; // analog clock divider
    logic [DEC_W-1:0] dec; // decimation value
    logic [1:0] filt_field; // filter select
    logic [7:0] stat; // sticky event bits
    logic [7:0] mask; // interrupt enables
    logic [RES_W-1:0] result; // last output word

    // counters and sequencer state
    logic [7:0] pre_cnt; // oscillator prescaler
    logic [5:0] mod_cnt; // fixed divide by 64
    logic [DEC_W-1:0] dec_cnt; // modulator samples in this word
    sdas_cal_state_e cal_state;
    logic [2:0] cal_mode; // procedure in progress
    logic [4:0] per_cnt; // data periods spent calibrating
    logic [1:0] conv_since; // conversions since input change

    // bus decode
    wire [7:0] idx = I_ADDRESS[9:2];
    wire req = I_READ | I_WRITE;
    wire take = req & ~O_WAITREQUEST; // the edge the master completes on
    wire wr = I_WRITE & take & I_BYTEENABLE[0];
    wire wr_ctrl = wr & (idx == `SDAS_IDX_CTRL_ONE);
    wire wr_dec_lo = wr & (idx == `SDAS_IDX_DEC_LOW);
    wire wr_dec_hi = wr & (idx == `SDAS_IDX_DEC_HIGH);
    wire wr_aclk = wr & (idx == `SDAS_IDX_ACLK);
    wire wr_stat = wr & (idx == `SDAS_IDX_AUX_STAT);
    wire wr_mask = wr & (idx == `SDAS_IDX_AUX_MASK);
    wire rd_result = I_READ & take & (idx == `SDAS_IDX_RESULT);

    // calibration code decode
    wire [2:0] new_cal = I_WRITEDATA[`SDAS_CAL_LSB +: 3];
    wire cal_valid = (new_cal != `SDAS_CAL_NONE) && (new_cal <= `SDAS_CAL_SYS_GAIN);
    wire cal_start = wr_ctrl & cal_valid;
    wire [4:0] cal_need = (cal_mode == `SDAS_CAL_SELF_BOTH) ? `SDAS_CAL_PERIODS_BOTH
                                                            : `SDAS_CAL_PERIODS;

    // timing decode
    // at-or-above, so a smaller divider written mid-count cannot cause a 256-cycle wrap
    wire pre_hit = (pre_cnt >= aclk_div);
    wire mod_hit = pre_hit & (mod_cnt == `SDAS_MOD_DIV_LAST);
    // a decimation of zero would never end a word, so it acts as one
    wire [DEC_W-1:0] dec_eff = (dec == '0) ? DEC_W'(1) : dec;
    wire dec_last = (dec_cnt >= dec_eff - DEC_W'(1));
    wire word_hit = mod_hit & dec_last;
    wire cal_busy = (cal_state == SDAS_CAL_RUN);
    wire cal_done = cal_busy & word_hit & (per_cnt == cal_need - 5'h01) & ~cal_start;
    wire data_evt = word_hit & ~cal_busy;

    // event bits: a set in the same cycle as a clear wins
    wire [7:0] stat_set = {2'h0, data_evt | cal_done, cal_done, 4'h0};
    wire [7:0] stat_clr = (wr_stat ? I_WRITEDATA[7:0] : 8'h00)
                        | (rd_result ? 8'h20 : 8'h00);
    wire [7:0] next_stat = (stat & ~stat_clr) | stat_set;

    // control register readback shows the running procedure
    wire [7:0] ctrl_view = {2'h0, filt_field, 1'b0, cal_mode};

    // read data selection; unmapped indexes read zero
    wire [31:0] next_rdata =
        (idx == `SDAS_IDX_AUX_STAT) ? {24'h0, stat} :
        (idx == `SDAS_IDX_AUX_MASK) ? {24'h0, mask} :
        (idx == `SDAS_IDX_RESULT) ? 32'(result) :
        (idx == `SDAS_IDX_CTRL_ONE) ? {24'h0, ctrl_view} :
        (idx == `SDAS_IDX_DEC_LOW) ? {24'h0, dec[7:0]} :
        (idx == `SDAS_IDX_DEC_HIGH) ? 32'(dec[DEC_W-1:8]) :
        (idx == `SDAS_IDX_ACLK) ? {24'h0, aclk_div} : 32'h0;

    // auto filter: fast for two conversions, sinc2 once, then sinc3
    sdas_filt_e auto_filt;
    sdas_filt_e next_filt;
    assign auto_filt = (conv_since < `SDAS_AUTO_FAST_CONV) ? SDAS_FILT_FAST :
                       (conv_since == `SDAS_AUTO_FAST_CONV) ? SDAS_FILT_SINC2 : SDAS_FILT_SINC3;
    assign next_filt = (filt_field == `SDAS_FSEL_AUTO) ? auto_filt :
                       (filt_field == `SDAS_FSEL_FAST) ? SDAS_FILT_FAST :
                       (filt_field == `SDAS_FSEL_SINC2) ? SDAS_FILT_SINC2 : SDAS_FILT_SINC3;
    // first conversion after a change is thrown away in auto mode
    wire next_discard = (filt_field == `SDAS_FSEL_AUTO) & (conv_since == 2'h0);

    // bus handshake: one wait cycle, then the answer for one cycle
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_WAITREQUEST <= 1'b1;
            O_READDATA <= 32'h0;
        end else if (I_CE) begin
            O_WAITREQUEST <= ~(req & O_WAITREQUEST);
            if (req & O_WAITREQUEST) begin
                O_READDATA <= next_rdata;
            end
        end
    end

    // software-written registers
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            aclk_div <= `SDAS_ACLK_RST;
            dec <= DEC_W'({`SDAS_DEC_HIGH_RST, `SDAS_DEC_LOW_RST});
            filt_field <= 2'(`SDAS_CTRL_RST >> `SDAS_FILT_LSB);
            mask <= `SDAS_MASK_RST;
        end else if (I_CE) begin
            if (wr_aclk) begin
                aclk_div <= I_WRITEDATA[7:0];
            end
            if (wr_dec_lo) begin
                dec[7:0] <= I_WRITEDATA[7:0];
            end
            if (wr_dec_hi) begin
                dec[DEC_W-1:8] <= I_WRITEDATA[DEC_W-9:0];
            end
            if (wr_ctrl) begin
                filt_field <= I_WRITEDATA[`SDAS_FILT_LSB +: 2];
            end
            if (wr_mask) begin
                mask <= I_WRITEDATA[7:0];
            end
        end
    end

    // modulator divider: prescale by divider+1, then by 64
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            pre_cnt <= 8'h00;
            mod_cnt <= 6'h00;
            O_MOD_TICK <= 1'b0;
        end else if (I_CE) begin
            pre_cnt <= pre_hit ? 8'h00 : pre_cnt + 8'h01;
            if (pre_hit) begin
                mod_cnt <= mod_cnt + 6'h01;
            end
            O_MOD_TICK <= mod_hit;
        end
    end

    // decimation: reloads after each output word
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            dec_cnt <= '0;
            O_WORD_TICK <= 1'b0;
            result <= '0;
        end else if (I_CE) begin
            if (mod_hit) begin
                dec_cnt <= dec_last ? '0 : dec_cnt + DEC_W'(1);
            end
            O_WORD_TICK <= word_hit;
            if (data_evt) begin
                result <= I_RESULT;
            end
        end
    end

    // calibration sequencer; a new valid code restarts the count
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cal_state <= SDAS_CAL_IDLE;
            cal_mode <= `SDAS_CAL_NONE;
            per_cnt <= 5'h00;
        end else if (I_CE) begin
            unique case (cal_state)
                SDAS_CAL_IDLE: begin
                    if (cal_start) begin
                        cal_state <= SDAS_CAL_RUN;
                        cal_mode <= new_cal;
                        per_cnt <= 5'h00;
                    end
                end
                SDAS_CAL_RUN: begin
                    if (cal_start) begin
                        cal_mode <= new_cal;
                        per_cnt <= 5'h00;
                    end else if (cal_done) begin
                        cal_state <= SDAS_CAL_IDLE;
                        cal_mode <= `SDAS_CAL_NONE;
                    end else if (word_hit) begin
                        per_cnt <= per_cnt + 5'h01;
                    end
                end
            endcase
        end
    end

    // events, interrupt and filter outputs
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            stat <= 8'h00;
            O_IRQ <= 1'b0;
            conv_since <= 2'h0;
            O_FILTER_SEL <= SDAS_FILT_FAST;
            O_DISCARD <= 1'b0;
            O_CAL_MODE <= `SDAS_CAL_NONE;
            O_CAL_BUSY <= 1'b0;
        end else if (I_CE) begin
            stat <= next_stat;
            // irq updates on the same edge as status, from a flop
            O_IRQ <= |(next_stat & mask);
            if (I_INPUT_CHANGE) begin
                conv_since <= 2'h0;
            end else if (word_hit && conv_since != 2'h3) begin
                conv_since <= conv_since + 2'h1;
            end
            O_FILTER_SEL <= next_filt;
            O_DISCARD <= next_discard;
            O_CAL_MODE <= cal_mode;
            O_CAL_BUSY <= cal_busy;
        end
    end

    // checks
    default clocking ck @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);

    sequence s_cal_end;
        I_CE && cal_done;
    endsequence
    sequence s_flags_up;
        stat[`SDAS_STAT_CONV] && stat[`SDAS_STAT_CAL] && !cal_busy;
    endsequence

    AST_MOD_TICK: assert property (I_CE && pre_hit && mod_cnt == 6'h3f |=> O_MOD_TICK && mod_cnt == 6'h00)
        else $error("modulator tick not raised after 64 prescaler wraps");
    AST_PRESCALE: assert property (I_CE && !pre_hit |=> pre_cnt == $past(pre_cnt) + 8'h01)
        else $error("prescaler did not advance");
    AST_WORD: assert property (I_CE && mod_hit && dec_cnt == dec_eff - DEC_W'(1) |=> O_WORD_TICK && dec_cnt == '0)
        else $error("output word not emitted at decimation count");
    AST_DATA_FLAG: assert property (I_CE && data_evt |=> stat[`SDAS_STAT_CONV])
        else $error("data-ready flag not set at word end");
    AST_CAL_START: assert property (I_CE && cal_start |=> ##1 O_CAL_BUSY && O_CAL_MODE == $past(new_cal, 2))
        else $error("calibration did not start with written code");
    AST_CAL_IDLE: assert property (!cal_busy |-> cal_mode == 3'h0)
        else $error("calibration code held while idle");
    AST_CAL_RSVD: assert property (I_CE && wr_ctrl && new_cal > 3'h5 && !cal_busy |=> !cal_busy)
        else $error("reserved calibration code started a procedure");
    AST_CAL_LEN: assert property (cal_done |-> per_cnt == ((cal_mode == 3'h1) ? 5'h0d : 5'h06))
        else $error("calibration length wrong");
    AST_CAL_DONE: assert property (s_cal_end |=> s_flags_up)
        else $error("calibration end did not raise flags");
    AST_RESULT_CLR: assert property (I_CE && rd_result && !data_evt && !cal_done |=> !stat[5])
        else $error("result read did not clear data-ready");
    AST_AUTO_SINC2: assert property (I_CE && filt_field == 2'h0 && conv_since == 2'h2
                                     |=> O_FILTER_SEL == SDAS_FILT_SINC2)
        else $error("auto mode skipped sinc2 conversion");
endmodule

// ==== dv/sdas_front_model.sv ====
/*
 * analog front end model: hands a result word to the sequencer at each
 * word end, zero or full scale while a system calibration runs.
 * assumes: one clock shared with the sequencer, active low async reset.
 */
`timescale 1ns/10ps
`include "sdas_defs.svh"

module sdas_front_model (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_word_tick,
    input wire logic i_cal_busy,
    input wire logic [2:0] i_cal_mode,
    output logic [23:0] o_result
);
    // system calibration inputs
    wire sys_ofs = i_cal_busy && (i_cal_mode == `SDAS_CAL_SYS_OFS);
    wire sys_gain = i_cal_busy && (i_cal_mode == `SDAS_CAL_SYS_GAIN);

    // new word after each word end: random, or a fixed zero or full scale during system calibration
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_result <= 24'h000000;
        end else if (i_word_tick) begin
            if (sys_ofs) begin
                o_result <= 24'h000000;
            end else if (sys_gain) begin
                o_result <= 24'h7fffff;
            end else begin
                o_result <= 24'($urandom);
            end
        end
    end
endmodule

// ==== dv/sdas_sequencer_test.sv ====
/*
 * self-checking bench of the converter sequencer: register bus, tick
 * rates, interrupt, calibration codes and filter selection.
 * assumes: design files and sdas_defs.svh compiled before this file.
 */
`timescale 1ns/10ps
`include "sdas_defs.svh"

module sdas_sequencer_test;
    logic clk, nrst, ce, rd, wr, chg, wt, mtk, wtk, cbusy, disc, irq, seen;
    logic [9:0] adr;
    logic [31:0] wd, rdat, q;
    logic [3:0] be;
    logic [2:0] cmode;
    logic [1:0] fsel;
    logic [23:0] res, rexp;
    int n_fail, tests_run, div, dec, n, k, c;

    sdas_sequencer uut (.I_CLK(clk), .I_NRST(nrst), .I_CE(ce), .I_ADDRESS(adr), .I_READ(rd), .I_WRITE(wr),
        .I_WRITEDATA(wd), .I_BYTEENABLE(be), .O_WAITREQUEST(wt), .O_READDATA(rdat), .I_INPUT_CHANGE(chg),
        .I_RESULT(res), .O_MOD_TICK(mtk), .O_WORD_TICK(wtk), .O_CAL_MODE(cmode), .O_CAL_BUSY(cbusy),
        .O_FILTER_SEL(fsel), .O_DISCARD(disc), .O_IRQ(irq));
    sdas_front_model front (.i_clk(clk), .i_nrst(nrst), .i_word_tick(wtk), .i_cal_busy(cbusy),
        .i_cal_mode(cmode), .o_result(res));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // verdict and end of run
    task results;
        if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    // one bus cycle; holds the request until waitrequest is sampled low
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int i;
        @(posedge clk);
        adr <= {idx, 2'b00};
        rd <= !w;
        wr <= w;
        wd <= {24'h000000, d};
        be <= 4'hf;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (wt === 1'b0) break;
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i == 50) begin
            chk("bus_timeout", 0, 1);
            results;
        end
    endtask

    // cycles from now up to the next tick of the chosen kind
    task tick(input bit w, output int m);
        m = 0;
        do begin
            @(posedge clk);
            #1;
            m++;
        end while (((w ? wtk : mtk) !== 1'b1) && m < 5000);
        if (m == 5000) begin
            chk("tick_timeout", 0, 1);
            results;
        end
    endtask

    task cyc(input int m);
        repeat (m) @(posedge clk);
        #1;
    endtask

    // word periods of one calibration code
    function automatic int cal_words(input int code);
        return (code == 1) ? 14 : 7;
    endfunction

    // filter of the k-th conversion after an input change in auto mode
    function automatic logic [1:0] exp_fsel(input int kk);
        return (kk < 2) ? 2'h0 : ((kk == 2) ? 2'h1 : 2'h2);
    endfunction

    // main sequence
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        chg = 1'b0;
        adr = 10'h000;
        wd = 32'h00000000;
        be = 4'h0;
        n_fail = 0;
        tests_run = 0;
        void'($urandom(95945));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        // reset values, unmapped place reads zero
        bus(0, `SDAS_IDX_CTRL_ONE, 8'h00); chk("ctrl_rst", `SDAS_CTRL_RST, q);
        bus(0, `SDAS_IDX_DEC_LOW, 8'h00); chk("dec_low_rst", `SDAS_DEC_LOW_RST, q);
        bus(0, `SDAS_IDX_DEC_HIGH, 8'h00); chk("dec_high_rst", `SDAS_DEC_HIGH_RST, q);
        bus(0, `SDAS_IDX_AUX_MASK, 8'h00); chk("mask_rst", `SDAS_MASK_RST, q);
        bus(1, 8'h10, 8'h5a);
        bus(0, 8'h10, 8'h00); chk("unmapped", 0, q);
        // small divider and decimation keep the run short
        div = $urandom_range(1, 0);
        dec = $urandom_range(4, 2);
        bus(1, `SDAS_IDX_ACLK, div[7:0]);
        bus(1, `SDAS_IDX_DEC_LOW, dec[7:0]);
        bus(1, `SDAS_IDX_DEC_HIGH, 8'h00);
        bus(0, `SDAS_IDX_DEC_LOW, 8'h00); chk("dec_low_rw", dec, q);
        tick(0, n);
        tick(0, n); chk("mod_gap", (div + 1) * 64, n);
        // clock enable low for ten edges stretches one modulator period by ten
        @(posedge clk);
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        tick(0, n); chk("ce_freeze", (div + 1) * 64 + 10, n + 11);
        tick(1, n);
        tick(1, n); chk("word_gap", dec * (div + 1) * 64, n);
        // data ready raises the interrupt; reading the result clears it
        bus(1, `SDAS_IDX_AUX_MASK, 8'h20);
        bus(1, `SDAS_IDX_AUX_STAT, 8'h30);
        tick(1, n);
        rexp = res;
        cyc(3); chk("irq_rise", 1, irq);
        bus(0, `SDAS_IDX_RESULT, 8'h00); chk("result", rexp, q[23:0]);
        bus(0, `SDAS_IDX_AUX_STAT, 8'h00); chk("stat_read_clr", 0, q[5]);
        cyc(2); chk("irq_fall", 0, irq);
        bus(1, `SDAS_IDX_AUX_MASK, 8'h00);
        tick(1, n);
        cyc(3); chk("irq_masked", 0, irq);
        bus(0, `SDAS_IDX_AUX_STAT, 8'h00); chk("stat_masked", 1, q[5]);
        // calibration codes 1 to 7, reserved ones included; first one after power-on
        for (c = 1; c < 8; c++) begin
            bus(1, `SDAS_IDX_AUX_STAT, 8'h30);
            // no buffer or offset trim control here: calibration runs with both untouched
            bus(1, `SDAS_IDX_CTRL_ONE, c[7:0]);
            if (c > 5) begin
                cyc(4); chk("rsv_busy", 0, cbusy);
                bus(0, `SDAS_IDX_CTRL_ONE, 8'h00); chk("rsv_code", 0, q[2:0]);
            end else begin
                n = 0;
                seen = 1'b0;
                for (k = 0; k < 20000; k++) begin
                    @(posedge clk);
                    #1;
                    if (wtk === 1'b1) n++;
                    if (cbusy === 1'b1 && !seen) chk("cal_mode", c, cmode);
                    if (cbusy === 1'b1) seen = 1'b1;
                    else if (seen) break;
                end
                chk("cal_words", cal_words(c), n);
                bus(0, `SDAS_IDX_AUX_STAT, 8'h00); chk("cal_done", 2'h3, q[5:4]);
            end
        end
        // fixed filters
        for (c = 1; c < 4; c++) begin
            bus(1, `SDAS_IDX_CTRL_ONE, {2'b00, c[1:0], 4'h0});
            cyc(3); chk("fsel_fixed", c - 1, fsel);
        end
        // auto mode: input change synchronised to a word end
        bus(1, `SDAS_IDX_CTRL_ONE, 8'h00);
        tick(1, n);
        @(posedge clk);
        chg <= 1'b1;
        @(posedge clk);
        chg <= 1'b0;
        for (k = 0; k < 5; k++) begin
            if (k > 0) tick(1, n);
            cyc(3); chk("auto_fsel", exp_fsel(k), fsel);
            chk("discard", k == 0, disc);
        end
        results;
    end
endmodule
